//--- rtl/acsif_dev.sv
// Purpose: Converter end of the serial command interface.
// Assumes: Link pins arrive asynchronous to clock and pass two flip-flops.
// Notes:   Output word is chosen by the command of the previous full frame.
//
// Summary of operation
// - Input frames arrive MSB first from bit 15.
// - First four bits decode to one of sixteen commands.
// - Config write takes twelve more bits as value.
// - Sync unused: start at select fall, sample rising.
// - Sync used: start at sync fall, sample falling.
// - Stop input after sixteen edges or select rise.
// - Output floats while select high until MSB.
// - Sync high: MSB at select fall, change falling.
// - Sync low: MSB at sync low, change rising.
// - Conversion frames: twelve result bits, four fillers.
// - Config readback: content in last twelve bits.
// - Output floats after sixteenth bit shifted out.
// - Host keeps serial clock low when idle.
// - Serial clock may drive the conversion clock.
// - Zero-padded trailing bits keep command meaning.
// - Results are straight binary, 000h to FFFh.
// - Bits 15-12 command, bits 11-0 data.
// - Sync falling while selected in sync style resets edge counter, enables input.
// - Frame starts at select fall or sync fall.
`timescale 1ns/10ps

// ==========================================================================
// Converter end
module acsif_dev
    import acsif_pkg::*;
(
    input wire logic clock,                         // System clock, 250 MHz
    input wire logic srst,                          // Synchronous reset, active high
    acsif_if.device lnk,                            // Serial link pins
    input wire logic [11:0] conv_result,            // Previous conversion result
    input wire logic [11:0] fifo_data,              // Queue head for queue reads
    input wire logic osc_tick,                      // Internal oscillator tick
    output logic cmd_valid,                         // Pulse: command decoded
    output logic [3:0] cmd_code,                    // Last decoded command
    output logic cfg_wr,                            // Pulse: config word written
    output logic [11:0] config_word_register,       // Stored configuration
    output logic conv_clk_sel,                      // Conversion clock from link
    output logic conv_clk_tick,                     // Conversion clock tick
    output logic frame_active                       // Frame in progress
);

    // ======================================================================
    // Pin synchronisers
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;

    // Two flops per pin, third stage only for edge detection
    always_ff @(posedge clock) begin
        if (srst) begin
            s1_r <= SY_RST;
            s2_r <= SY_RST;
            s3_r <= SY_RST;
        end else begin
            s1_r <= {lnk.frame_sync, lnk.sdi, lnk.sclk, lnk.cs_n};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Edge decode of synchronised pins
    wire cs_fall = s3_r[SY_CS] & ~s2_r[SY_CS];
    wire cs_rise = ~s3_r[SY_CS] & s2_r[SY_CS];
    wire clk_rise = ~s3_r[SY_CLK] & s2_r[SY_CLK];
    wire clk_fall = s3_r[SY_CLK] & ~s2_r[SY_CLK];
    wire fs_fall = s3_r[SY_FS] & ~s2_r[SY_FS];
    wire fs_lvl = s2_r[SY_FS];
    wire di = s2_r[SY_DI];

    // ======================================================================
    // Frame control
    acsif_dev_st_t st_r;
    acsif_dev_st_t st_nxt;
    logic fs_mode_r;
    logic [3:0] cnt_r;
    logic started_r;
    logic [15:0] rx_r;
    logic [15:0] tx_r;
    logic oe_n_r;
    logic [3:0] prev_cmd_r;

    // Sampling and change edges follow the mode caught at select fall
    wire smp_edge = fs_mode_r ? clk_fall : clk_rise;
    wire chg_edge = fs_mode_r ? clk_rise : clk_fall;
    wire in_shift = (st_r == DEV_SHIFT);
    wire take_bit = in_shift & smp_edge & ~cs_rise;
    wire fs_restart = (st_r != DEV_IDLE) & fs_mode_r & fs_fall & ~cs_rise;
    wire frame_start = ((st_r == DEV_IDLE) & cs_fall) | fs_restart;
    wire last_smp = take_bit & (cnt_r == CNT_LAST);
    wire cmd_smp = take_bit & (cnt_r == CNT_CMD);
    wire [3:0] cmd_now = {rx_r[2:0], di};
    wire [11:0] cfg_now = {rx_r[10:0], di};
    wire fs_mode_nxt = (st_r == DEV_IDLE) ? ~fs_lvl : fs_mode_r;

    // Output word by previous command: readback, queue or result
    wire [15:0] word_cfg = {PAD_NIBBLE, config_word_register};
    wire [15:0] word_fifo = {fifo_data, PAD_NIBBLE};
    wire [15:0] word_conv = {conv_result, PAD_NIBBLE};
    wire [15:0] tx_sel = (prev_cmd_r == CMD_RD_CFG) ? word_cfg :
                         (prev_cmd_r == CMD_FIFO_RD) ? word_fifo : word_conv;

    // Next state: select rise always wins and ends the frame
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            DEV_IDLE: begin
                if (cs_fall) begin
                    st_nxt = DEV_SHIFT;
                end
            end
            DEV_ARMED: begin
                if (cs_rise) begin
                    st_nxt = DEV_IDLE;
                end else if (fs_restart) begin
                    st_nxt = DEV_SHIFT;
                end
            end
            DEV_SHIFT: begin
                if (cs_rise) begin
                    st_nxt = DEV_IDLE;
                end else if (fs_restart) begin
                    st_nxt = DEV_SHIFT;
                end else if (last_smp) begin
                    st_nxt = DEV_ARMED;
                end
            end
            default: begin
                st_nxt = DEV_IDLE;
            end
        endcase
    end

    // State and mode
    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= DEV_IDLE;
            fs_mode_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            fs_mode_r <= fs_mode_nxt;
        end
    end

    // Edge counter and first-sample flag
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_r <= 4'h0;
            started_r <= 1'b0;
        end else if (frame_start) begin
            cnt_r <= 4'h0;
            started_r <= 1'b0;
        end else if (take_bit) begin
            cnt_r <= cnt_r + 4'h1;
            started_r <= 1'b1;
        end
    end

    // Receive shifter, MSB enters first
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_r <= 16'h0000;
        end else if (take_bit) begin
            rx_r <= {rx_r[14:0], di};
        end
    end

    // Transmit shifter; no shift before the first sample of the frame
    always_ff @(posedge clock) begin
        if (srst) begin
            tx_r <= 16'h0000;
        end else if (frame_start) begin
            tx_r <= tx_sel;
        end else if (in_shift & chg_edge & started_r) begin
            tx_r <= {tx_r[14:0], 1'b0};
        end
    end

    // Output enable follows the shift state
    always_ff @(posedge clock) begin
        if (srst) begin
            oe_n_r <= 1'b1;
        end else begin
            oe_n_r <= (st_nxt != DEV_SHIFT);
        end
    end

    assign lnk.sdo = tx_r[15];
    assign lnk.sdo_oe_n = oe_n_r;

    // ======================================================================
    // Command and configuration
    logic cmd_valid_r;
    logic [3:0] cmd_code_r;
    logic cfg_wr_r;
    logic [11:0] cfg_r;

    // Command decode after the fourth bit
    always_ff @(posedge clock) begin
        if (srst) begin
            cmd_valid_r <= 1'b0;
            cmd_code_r <= 4'h0;
        end else begin
            cmd_valid_r <= cmd_smp;
            if (cmd_smp) begin
                cmd_code_r <= cmd_now;
            end
        end
    end

    // Config write at the 16th bit; remember command for next output word
    always_ff @(posedge clock) begin
        if (srst) begin
            cfg_wr_r <= 1'b0;
            cfg_r <= CFG_RST;
            prev_cmd_r <= 4'h0;
        end else begin
            cfg_wr_r <= last_smp & (cmd_code_r == CMD_WR_CFG);
            if (last_smp & (cmd_code_r == CMD_WR_CFG)) begin
                cfg_r <= cfg_now;
            end
            if (last_smp) begin
                prev_cmd_r <= cmd_code_r;
            end
        end
    end

    // ======================================================================
    // Conversion clock source and status
    logic conv_clk_sel_r;
    logic conv_clk_tick_r;
    logic frame_active_r;

    wire clk_from_link = (cfg_r[CFG_CLKSRC_HI:CFG_CLKSRC_LO] != CLKSRC_OSC);

    // Tick from link clock rises or from the internal oscillator
    always_ff @(posedge clock) begin
        if (srst) begin
            conv_clk_sel_r <= 1'b0;
            conv_clk_tick_r <= 1'b0;
            frame_active_r <= 1'b0;
        end else begin
            conv_clk_sel_r <= clk_from_link;
            conv_clk_tick_r <= clk_from_link ? clk_rise : osc_tick;
            frame_active_r <= (st_nxt == DEV_SHIFT);
        end
    end

    assign cmd_valid = cmd_valid_r;
    assign cmd_code = cmd_code_r;
    assign cfg_wr = cfg_wr_r;
    assign config_word_register = cfg_r;
    assign conv_clk_sel = conv_clk_sel_r;
    assign conv_clk_tick = conv_clk_tick_r;
    assign frame_active = frame_active_r;

endmodule : acsif_dev

//--- rtl/acsif_pkg.sv
// Purpose: Shared constants and types for the converter serial command interface.
// Assumes: 250 MHz system clock on both ends; link clock made by the host end.
// Notes:   Frames are 16 bits, 4-bit command then 12-bit data, MSB first.

// ==========================================================================
// Package
package acsif_pkg;
    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int CMD_W = 4;
    localparam int DATA_W = 12;
    localparam logic [3:0] CNT_CMD = 4'h3;      // Edge index of last command bit
    localparam logic [3:0] CNT_LAST = 4'hf;     // Edge index of 16th bit
    localparam logic [3:0] PAD_NIBBLE = 4'h0;   // Filler nibble in output words

    // Command codes; the interface itself acts on all but CMD_PWR_DOWN
    localparam logic [3:0] CMD_PWR_DOWN = 4'h8;
    localparam logic [3:0] CMD_RD_CFG = 4'h9;
    localparam logic [3:0] CMD_WR_CFG = 4'ha;
    localparam logic [3:0] CMD_FIFO_RD = 4'he;

    // Configuration word
    localparam logic [11:0] CFG_RST = 12'h000;
    localparam int CFG_CLKSRC_HI = 8;
    localparam int CFG_CLKSRC_LO = 7;
    localparam logic [1:0] CLKSRC_OSC = 2'h0;

    // Synchroniser lanes and their reset levels
    localparam int SY_CS = 0;
    localparam int SY_CLK = 1;
    localparam int SY_DI = 2;
    localparam int SY_FS = 3;
    localparam logic [3:0] SY_RST = 4'h9;        // Select high, clock low, sync high
    localparam logic [1:0] SDO_SY_RST = 2'h0;

    // Link clock made by the host: half period in ns, rounded down to cycles
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCLK_HALF_NS = 40;
    localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;
    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);
    localparam logic [5:0] HALVES_LAST = 6'h1f;  // 32 half periods per frame

    typedef enum logic [2:0] {
        DEV_IDLE = 3'b001,
        DEV_ARMED = 3'b010,
        DEV_SHIFT = 3'b100
    } acsif_dev_st_t;

    typedef enum logic [3:0] {
        HST_IDLE = 4'b0001,
        HST_LEAD = 4'b0010,
        HST_RUN = 4'b0100,
        HST_TAIL = 4'b1000
    } acsif_hst_st_t;
endpackage : acsif_pkg

//--- rtl/acsif_if.sv
// Purpose: Serial link between host end and converter end.
// Assumes: Testbench resolves the 3-state output from sdo and sdo_oe_n.
// Notes:   No clocking block; the device samples its four input pins and the host samples sdo through synchronisers.
`timescale 1ns/10ps

// ==========================================================================
// Interface
interface acsif_if;
    logic cs_n;         // Chip select, active low
    logic sclk;         // Serial clock, rests low
    logic sdi;          // Serial data towards the converter
    logic frame_sync;   // Frame sync, high when unused
    logic sdo;          // Serial data from the converter
    logic sdo_oe_n;     // Output enable of sdo, low while driven

    modport device (input cs_n, input sclk, input sdi, input frame_sync,
                    output sdo, output sdo_oe_n);
    modport host (output cs_n, output sclk, output sdi, output frame_sync,
                  input sdo, input sdo_oe_n);
endinterface : acsif_if

//--- rtl/acsif_host.sv
// Purpose: Host end of the serial command interface, one 16-bit frame per start.
// Assumes: Link clock is made here by dividing the system clock.
// Notes:   Returned data is sampled from a two-flop synchronised copy.
`timescale 1ns/10ps

// ==========================================================================
// Host end
module acsif_host
    import acsif_pkg::*;
(
    input wire logic clock,             // System clock, 250 MHz
    input wire logic srst,              // Synchronous reset, active high
    acsif_if.host lnk,                  // Serial link pins
    input wire logic start,             // Pulse: send one frame
    input wire logic use_fs,            // Level: frame sync style
    input wire logic [15:0] tx_word,    // Command and data, MSB first
    output logic busy,                  // Frame in progress
    output logic done,                  // Pulse: frame complete
    output logic [15:0] rx_word         // Word returned by the device
);

    acsif_hst_st_t st_r;
    logic [7:0] div_r;
    logic [5:0] half_r;
    logic mode_r;
    logic cs_n_r;
    logic sclk_r;
    logic fs_r;
    logic [15:0] sh_r;
    logic [15:0] rx_r;
    logic [1:0] sdo_sy_r;
    logic busy_r;
    logic done_r;

    // Divider tick and link edge decode
    wire tick = (div_r == HALF_LAST);
    wire go = (st_r == HST_IDLE) & start;
    wire rise = (st_r == HST_RUN) & tick & ~sclk_r;
    wire fall = (st_r == HST_RUN) & tick & sclk_r;
    wire smp = mode_r ? fall : rise;
    wire chg = (mode_r ? rise : fall) & (half_r != 6'h00);
    wire last = fall & (half_r == HALVES_LAST);

    // Returned data synchroniser
    always_ff @(posedge clock) begin
        if (srst) begin
            sdo_sy_r <= SDO_SY_RST;
        end else begin
            sdo_sy_r <= {sdo_sy_r[0], lnk.sdo};
        end
    end

    // Sequencer: lead half period, 32 halves, tail half period
    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= HST_IDLE;
            div_r <= 8'h00;
            half_r <= 6'h00;
        end else begin
            div_r <= (go | tick) ? 8'h00 : div_r + 8'h01;
            if (rise | fall) begin
                half_r <= half_r + 6'h01;
            end
            case (st_r)
                HST_IDLE: begin
                    if (go) begin
                        st_r <= HST_LEAD;
                        half_r <= 6'h00;
                    end
                end
                HST_LEAD: begin
                    if (tick) begin
                        st_r <= HST_RUN;
                    end
                end
                HST_RUN: begin
                    if (last) begin
                        st_r <= HST_TAIL;
                    end
                end
                HST_TAIL: begin
                    if (tick) begin
                        st_r <= HST_IDLE;
                    end
                end
                default: begin
                    st_r <= HST_IDLE;
                end
            endcase
        end
    end

    // Pins: clock rests low, select held over the frame
    always_ff @(posedge clock) begin
        if (srst) begin
            cs_n_r <= 1'b1;
            sclk_r <= 1'b0;
            fs_r <= 1'b1;
            mode_r <= 1'b0;
        end else begin
            if (go) begin
                cs_n_r <= 1'b0;
                fs_r <= ~use_fs;
                mode_r <= use_fs;
            end else if (st_r == HST_TAIL & tick) begin
                cs_n_r <= 1'b1;
            end
            if (rise | fall) begin
                sclk_r <= ~sclk_r;
            end
            if (fall) begin
                fs_r <= 1'b1;
            end
        end
    end

    // Data out MSB first, zero fill behind; data in MSB first
    always_ff @(posedge clock) begin
        if (srst) begin
            sh_r <= 16'h0000;
            rx_r <= 16'h0000;
        end else begin
            if (go) begin
                sh_r <= tx_word;
            end else if (chg) begin
                sh_r <= {sh_r[14:0], 1'b0};
            end
            if (smp) begin
                rx_r <= {rx_r[14:0], sdo_sy_r[1]};
            end
        end
    end

    // Status
    always_ff @(posedge clock) begin
        if (srst) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            busy_r <= go | (busy_r & ~(st_r == HST_TAIL & tick));
            done_r <= (st_r == HST_TAIL) & tick;
        end
    end

    assign lnk.cs_n = cs_n_r;
    assign lnk.sclk = sclk_r;
    assign lnk.sdi = sh_r[15];
    assign lnk.frame_sync = fs_r;
    assign busy = busy_r;
    assign done = done_r;
    assign rx_word = rx_r;

endmodule : acsif_host

//--- tb/acsif_asserts.sv
// Purpose: Wire checks on the link joining the host and converter ends.
// Assumes: One clock domain; pins sampled raw by the system clock.
// Notes:   Sample edges are counted here to find the end of a frame.
`timescale 1ns/10ps

// ==========================================================================
// Checker
module acsif_asserts (
    input wire logic clock, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic cs_n, // Select, active low
    input wire logic sclk, // Link clock
    input wire logic sdi, // Data to converter
    input wire logic frame_sync, // Frame sync, active low
    input wire logic sdo, // Data from converter
    input wire logic sdo_oe_n // Output enable, low while driven
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // ======================================================================
    // Helper logic
    logic sclk_r;
    logic cs_r;
    logic fs_mode_r;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    wire smp_edge = fs_mode_r ? (sclk_r && !sclk) : (!sclk_r && sclk);
    wire cnt_full = (cnt_r == 5'h10);
    assign cnt_nxt = cs_n ? 5'h00 : ((smp_edge && !cnt_full) ? cnt_r + 5'h01 : cnt_r);

    // Latch the frame style at select fall and count sample edges
    always_ff @(posedge clock) begin
        sclk_r <= srst ? 1'b0 : sclk;
        cs_r <= srst ? 1'b1 : cs_n;
        fs_mode_r <= srst ? 1'b0 : ((cs_r && !cs_n) ? !frame_sync : fs_mode_r);
        cnt_r <= srst ? 5'h00 : cnt_nxt;
    end

    // ======================================================================
    // Properties
    sequence s_start;
        $fell(cs_n);
    endsequence
    sequence s_drive;
        ##[2:6] !sdo_oe_n;
    endsequence

    property p_clk_idle; cs_n |-> !sclk; endproperty
    property p_reset_idle; $fell(srst) |-> sdo_oe_n; endproperty
    property p_float_sel; cs_n [*4] |-> sdo_oe_n; endproperty
    property p_msb_cs; s_start ##0 frame_sync |-> s_drive; endproperty
    property p_msb_fs; s_start ##0 !frame_sync |-> s_drive; endproperty
    property p_hold_cs;
        $rose(sclk) && !fs_mode_r |-> (sdo_oe_n || $stable(sdo)) [*3];
    endproperty
    property p_hold_fs;
        $fell(sclk) && fs_mode_r |-> (sdo_oe_n || $stable(sdo)) [*3];
    endproperty
    property p_sdi_hold; $rose(sclk) && !fs_mode_r |-> $stable(sdi); endproperty
    property p_float_16; cnt_full && $past(cnt_r) == 5'h0f |-> ##[1:8] sdo_oe_n; endproperty
    property p_stop_16; cnt_full && sdo_oe_n |=> sdo_oe_n; endproperty

    a_clk_idle: assert property (p_clk_idle) else $error("clock moved while idle");
    a_reset_idle: assert property (p_reset_idle) else $error("driven after reset");
    a_float_sel: assert property (p_float_sel) else $error("driven while deselected");
    a_msb_cs: assert property (p_msb_cs) else $error("first bit late, select style");
    a_msb_fs: assert property (p_msb_fs) else $error("first bit late, sync style");
    a_hold_cs: assert property (p_hold_cs) else $error("output moved at rise");
    a_hold_fs: assert property (p_hold_fs) else $error("output moved at fall");
    a_sdi_hold: assert property (p_sdi_hold) else $error("input moved at rise");
    a_float_16: assert property (p_float_16) else $error("not released after 16");
    a_stop_16: assert property (p_stop_16) else $error("driven after 16 edges");
endmodule : acsif_asserts

//--- tb/acsif_test.sv
// Purpose: Self-checking bench joining host and converter ends.
// Assumes: Second converter end is bit-banged by the bench for fault cases.
// Notes:   Released output line shows the inverse of its last value.
`timescale 1ns/10ps

// ==========================================================================
// Testbench
module acsif_test import acsif_pkg::*;;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic start = 1'b0;
    logic use_fs = 1'b0;
    logic [15:0] tx_word = 16'h0000;
    logic [11:0] conv_result = 12'h000;
    logic [11:0] fifo_data = 12'h3c6;
    logic osc_tick = 1'b0;
    logic busy, done, cmd_valid, cfg_wr, conv_clk_sel, conv_clk_tick, frame_active;
    logic [15:0] rx_word;
    logic [3:0] cmd_code;
    logic [11:0] cfg_word, cfg2, cfg_exp;
    logic [3:0] prev;
    int fail_count = 0;
    int check_count = 0;
    int n_cmd = 0;
    int n_wr = 0;
    int nf = 0;
    int n_tick = 0;
    int t0;
    acsif_if if_h();
    acsif_if if_d();
    acsif_if if_b();

    // Join the ends; a released output shows the inverse of its last value
    assign if_d.cs_n = if_h.cs_n;
    assign if_d.sclk = if_h.sclk;
    assign if_d.sdi = if_h.sdi;
    assign if_d.frame_sync = if_h.frame_sync;
    assign if_h.sdo_oe_n = if_d.sdo_oe_n;
    assign if_h.sdo = if_d.sdo_oe_n ? ~if_d.sdo : if_d.sdo;

    acsif_host acsif_host_inst (.clock(clock), .srst(srst), .lnk(if_h.host), .start(start),
        .use_fs(use_fs), .tx_word(tx_word), .busy(busy), .done(done), .rx_word(rx_word));
    acsif_dev acsif_dev_inst (.clock(clock), .srst(srst), .lnk(if_d.device),
        .conv_result(conv_result), .fifo_data(fifo_data), .osc_tick(osc_tick),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cfg_wr(cfg_wr),
        .config_word_register(cfg_word), .conv_clk_sel(conv_clk_sel),
        .conv_clk_tick(conv_clk_tick), .frame_active(frame_active));
    acsif_dev acsif_dev_inst_b (.clock(clock), .srst(srst), .lnk(if_b.device),
        .conv_result(conv_result), .fifo_data(fifo_data), .osc_tick(osc_tick),
        .cmd_valid(), .cmd_code(), .cfg_wr(), .config_word_register(cfg2),
        .conv_clk_sel(), .conv_clk_tick(), .frame_active());
    acsif_asserts acsif_asserts_inst (.clock(clock), .srst(srst), .cs_n(if_h.cs_n),
        .sclk(if_h.sclk), .sdi(if_h.sdi), .frame_sync(if_h.frame_sync), .sdo(if_d.sdo),
        .sdo_oe_n(if_d.sdo_oe_n));

    // Clock and pulse counters
    always #2 clock = ~clock;
    always @(posedge clock) begin
        if (cmd_valid === 1'b1) n_cmd++;
        if (cfg_wr === 1'b1) n_wr++;
        if (conv_clk_tick === 1'b1) n_tick++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One host frame, waiting for done under a bound
    task automatic xfer(input logic f, input logic [15:0] w);
        int k;
        @(posedge clock);
        start <= 1'b1;
        use_fs <= f;
        tx_word <= w;
        @(posedge clock);
        start <= 1'b0;
        nf++;
        k = 0;
        while (done !== 1'b1 && k < 600) begin
            @(posedge clock);
            #1;
            k++;
        end
        chk({15'h0000, done}, 16'h0001);
    endtask : xfer

    // Bit-bang n edges into the second end; a sync fall restarts a frame
    // Select style moves data at falls, sync style at rises, so each bit
    // stands a full half period before the edge that samples it
    task automatic bang(input logic f, input logic [15:0] w, input int n);
        if_b.frame_sync <= 1'b1;
        tick(4);
        if_b.cs_n <= 1'b0;
        if_b.frame_sync <= ~f;
        tick(10);
        for (int i = 0; i < n; i++) begin
            if (!f) begin
                if_b.sdi <= (i < 16) ? w[15 - i] : 1'b1;
            end
            tick(10);
            if_b.sclk <= 1'b1;
            if (f) begin
                if_b.sdi <= (i < 16) ? w[15 - i] : 1'b1;
            end
            tick(10);
            if_b.sclk <= 1'b0;
        end
        tick(10);
    endtask : bang

    task automatic bang_end(input logic [11:0] exp);
        if_b.cs_n <= 1'b1;
        tick(6);
        chk({4'h0, cfg2}, {4'h0, exp});
    endtask : bang_end

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    // Watchdog
    initial begin
        tick(30000);
        fail_count++;
        end_sim();
    end

    // Main sequence
    initial begin
        if_b.cs_n = 1'b1;
        if_b.sclk = 1'b0;
        if_b.sdi = 1'b0;
        if_b.frame_sync = 1'b1;
        tick(4);
        srst <= 1'b0;
        tick(3);
        #1;
        chk({cfg_word, 1'b0, if_d.sdo_oe_n, frame_active, busy}, 16'h0004);
        @(posedge clock);
        osc_tick <= 1'b1;
        @(posedge clock);
        osc_tick <= 1'b0;
        #1;
        chk({15'h0000, conv_clk_tick}, 16'h0001);
        prev = 4'h0;
        cfg_exp = CFG_RST;
        for (int i = 0; i < 16; i++) begin
            conv_result <= i[0] ? 12'hfff : 12'h000;
            xfer(i[0], {4'(i), (4'(i) == CMD_WR_CFG) ? 12'h180 : 12'h000});
            if (prev == CMD_RD_CFG) chk(rx_word, {PAD_NIBBLE, cfg_exp});
            else if (prev == CMD_FIFO_RD) chk(rx_word, {fifo_data, PAD_NIBBLE});
            else chk(rx_word, {i[0] ? 12'hfff : 12'h000, PAD_NIBBLE});
            if (4'(i) == CMD_WR_CFG) cfg_exp = 12'h180;
            chk({cmd_code, cfg_word}, {4'(i), cfg_exp});
            prev = 4'(i);
        end
        t0 = n_tick;
        xfer(1'b0, 16'h9000);
        chk(16'(n_tick - t0), 16'h0010);
        xfer(1'b1, 16'h0000);
        chk(rx_word, {PAD_NIBBLE, 12'h180});
        chk({15'h0000, conv_clk_sel}, 16'h0001);
        @(posedge clock);
        osc_tick <= 1'b1;
        @(posedge clock);
        osc_tick <= 1'b0;
        #1;
        chk({15'h0000, conv_clk_tick}, 16'h0000);
        chk(16'(n_cmd), 16'(nf));
        chk(16'(n_wr), 16'h0001);
        bang(1'b0, 16'ha123, 16);
        bang_end(12'h123);
        bang(1'b0, 16'ha0ff, 8);
        bang_end(12'h123);
        bang(1'b1, 16'hf0f0, 6);
        bang(1'b1, 16'ha055, 20);
        bang_end(12'h055);
        end_sim();
    end
endmodule : acsif_test
